// ==== bpc_map.svh ====
// Purpose: Widths, commands and timing of the bypass program controller.
// Assumes: A 100 MHz system clock and a 16-bit flash data bus.
// Notes: Times are given in their unit and turned into cycles here.
// Notes on behaviour
// R1: Word count above 127 or other sector errors.
// R2: Each buffer data write decrements the countdown.
// R3: Confirm x29h at loaded sector when countdown -1.
// R4: Finished programming returns to bypass idle itself.
// R5: Hang with ready status needs xF0h reset.
// R6: Enhanced suspend x51h only while programming busy.
// R7: Suspend request becomes suspended within latency.
// R8: Resume x50h returns to bypass programming.
// R9: Legacy resume x30h also returns to programming.
// R10: Status read x70h at x555h keeps state.
// R11: Host never uses legacy suspend xB0h.
// R12: Single-word entry next write starts programming.
// R13: Undefined commands during programming are never sent.
`ifndef BPC_MAP_SVH
`define BPC_MAP_SVH

// Bus geometry.
`define BPC_ADDR_W 22
`define BPC_DATA_W 16
`define BPC_SECT_LSB 15
`define BPC_WC_MAX 127

// Command addresses and data codes.
`define BPC_ADDR_STATUS 22'h000555
`define BPC_CMD_BUF_ENTER 16'h0025
`define BPC_CMD_CONFIRM 16'h0029
`define BPC_CMD_WORD 16'h00a0
`define BPC_CMD_RESET 16'h00f0
`define BPC_CMD_SUSPEND 16'h0051
`define BPC_CMD_RESUME 16'h0050
`define BPC_CMD_RESUME_OLD 16'h0030
`define BPC_CMD_SUSPEND_OLD 16'h00b0
`define BPC_CMD_STATUS 16'h0070

// Status register fields.
`define BPC_SR_READY 7
`define BPC_SR_PROG_ERR 4

// Clock rate and timing, cycle counts round least times up.
`define BPC_CLK_MHZ 100
`define BPC_T_WP_NS 40
`define BPC_T_ACC_NS 80
`define BPC_T_SUSP_US 40
`define BPC_WP_CYC ((`BPC_T_WP_NS * `BPC_CLK_MHZ + 999) / 1000)
`define BPC_ACC_CYC ((`BPC_T_ACC_NS * `BPC_CLK_MHZ + 999) / 1000)
`define BPC_SUSP_CYC (`BPC_T_SUSP_US * `BPC_CLK_MHZ)

`endif

// ==== bpc_pkg.sv ====
// Purpose: Types shared by the bypass program controller.
// Assumes: bpc_map.svh supplies the widths.
// Notes: Pin group and user command travel as packed structs.
`include "bpc_map.svh"
package bpc_pkg;

	// User operations accepted on the command port.
	typedef enum logic [2:0] {
		op_buf_prog,
		op_word_prog,
		op_suspend,
		op_resume,
		op_status,
		op_read,
		op_reset
	} bpc_op_type;

	// One user command.
	typedef struct packed {
		bpc_op_type op;
		logic [`BPC_ADDR_W-1:0] addr;
		logic [6:0] words_m1;
	} bpc_cmd_type;

	// Flash pins driven by the controller.
	typedef struct packed {
		logic [`BPC_ADDR_W-1:0] addr;
		logic [`BPC_DATA_W-1:0] dq_out;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
	} bpc_pins_type;

	// Pins at rest: chip deselected, bus released.
	localparam bpc_pins_type BPC_PINS_IDLE = '{addr: '0, dq_out: '0, dq_oe: 1'b0,
		ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};

	// Bus cycle engine states.
	typedef enum logic [1:0] {
		b_idle,
		b_setup,
		b_strobe,
		b_hold
	} bpc_bus_state_type;

	// Controller states; the bypass_* ones mirror the device.
	typedef enum logic [4:0] {
		st_bypass_idle,
		st_buf_enter,
		st_bypass_buffer_load,
		st_bypass_buffer_data,
		st_buf_confirm,
		st_word_cmd,
		st_bypass_single_word_entry,
		st_bypass_programming,
		st_stat_cmd,
		st_stat_read,
		st_array_read,
		st_check,
		st_bypass_suspend_request,
		st_bypass_program_suspended,
		st_resume,
		st_sw_reset,
		st_wait
	} bpc_state_type;

endpackage

// ==== bpc_bus_cycle.sv ====
// Purpose: Runs one asynchronous write or read cycle on the flash pins.
// Assumes: The caller waits for done before starting the next cycle.
// Notes: Setup, strobe and hold phases; a read samples the data bus at strobe end.
`timescale 1ns/100ps
`include "bpc_map.svh"
module bpc_bus_cycle
	import bpc_pkg::*;
#(
	parameter int WP_CYC = `BPC_WP_CYC,
	parameter int ACC_CYC = `BPC_ACC_CYC
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic start,
	input wire logic write,
	input wire logic [`BPC_ADDR_W-1:0] addr,
	input wire logic [`BPC_DATA_W-1:0] data,
	input wire logic [`BPC_DATA_W-1:0] dq_in,
	output logic done,
	output logic [`BPC_DATA_W-1:0] rdata,
	output bpc_pins_type pins
);

	bpc_bus_state_type bst_reg, bst_next; // Cycle phase.
	logic [7:0] cnt_reg, cnt_next; // Strobe length counter.
	logic write_reg, write_next; // Cycle direction.
	bpc_pins_type pins_reg, pins_next; // Registered pin values.
	logic [`BPC_DATA_W-1:0] rdata_reg, rdata_next; // Last read word.
	logic done_reg, done_next; // One-cycle end marker.

	// Phase sequencing; pins only change on clock edges so no glitches reach the chip.
	always_comb begin
		bst_next = bst_reg;
		cnt_next = cnt_reg;
		write_next = write_reg;
		pins_next = pins_reg;
		rdata_next = rdata_reg;
		done_next = 1'b0;
		case (bst_reg)
			b_idle: begin
				// Address and data settle one cycle before the strobe.
				if (start) begin
					write_next = write;
					pins_next.addr = addr;
					pins_next.dq_out = data;
					pins_next.dq_oe = write;
					pins_next.ce_n = 1'b0;
					bst_next = b_setup;
				end
			end
			b_setup: begin
				// Open the strobe that fits the direction.
				pins_next.we_n = ~write_reg;
				pins_next.oe_n = write_reg;
				cnt_next = write_reg ? 8'(WP_CYC - 1) : 8'(ACC_CYC - 1);
				bst_next = b_strobe;
			end
			b_strobe: begin
				// Hold the strobe for its full width, then sample a read.
				if (cnt_reg == 8'h00) begin
					if (!write_reg) begin
						rdata_next = dq_in;
					end
					pins_next.we_n = 1'b1;
					pins_next.oe_n = 1'b1;
					bst_next = b_hold;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			default: begin
				// Data holds one cycle past the strobe, then the bus is released.
				pins_next = BPC_PINS_IDLE;
				done_next = 1'b1;
				bst_next = b_idle;
			end
		endcase
	end

	// State registers.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bst_reg <= b_idle;
			cnt_reg <= 8'h00;
			write_reg <= 1'b0;
			pins_reg <= BPC_PINS_IDLE;
			rdata_reg <= 16'h0000;
			done_reg <= 1'b0;
		end else begin
			bst_reg <= bst_next;
			cnt_reg <= cnt_next;
			write_reg <= write_next;
			pins_reg <= pins_next;
			rdata_reg <= rdata_next;
			done_reg <= done_next;
		end
	end

	assign done = done_reg;
	assign rdata = rdata_reg;
	assign pins = pins_reg;

endmodule

// ==== bpc_host.sv ====
// Purpose: Drives bypass buffered and word programming on a NOR flash.
// Assumes: The device is already in unlock bypass mode.
// Notes: Programming progress is followed by status polling; suspend entry waits out a timed latency.
`timescale 1ns/100ps
`include "bpc_map.svh"
module bpc_host
	import bpc_pkg::*;
#(
	parameter int SUSP_CYC = `BPC_SUSP_CYC,
	parameter bit LEGACY_RESUME = 1'b0
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire bpc_cmd_type cmd,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [`BPC_DATA_W-1:0] wr_data,
	output logic done,
	output logic fail,
	output logic rd_valid,
	output logic [`BPC_DATA_W-1:0] rd_data,
	output logic suspended,
	input wire logic [`BPC_DATA_W-1:0] flash_dq_in,
	output bpc_pins_type flash_pins
);

	localparam int SW = `BPC_ADDR_W - `BPC_SECT_LSB; // Sector number width.

	bpc_state_type state_reg, state_next; // Current step.
	bpc_state_type ret_reg, ret_next; // Step after the running bus cycle.
	bpc_state_type home_reg, home_next; // Device state to fall back to.
	logic [7:0] cnt_reg, cnt_next; // Word countdown, two's complement.
	logic [`BPC_ADDR_W-1:0] addr_reg, addr_next; // Next data address.
	logic [SW-1:0] sect_reg, sect_next; // Sector loaded with the buffer.
	logic stat_reg, stat_next; // The pending read is a status read.
	logic busy_reg, busy_next; // Last poll showed programming busy.
	logic [15:0] lat_reg, lat_next; // Suspend latency counter.
	logic done_reg, done_next; // Completion pulse.
	logic fail_reg, fail_next; // Failure pulse.
	logic rdv_reg, rdv_next; // Read data pulse.
	logic [`BPC_DATA_W-1:0] rdat_reg, rdat_next; // Last word read.
	logic cyc_start; // Launch a bus cycle.
	logic cyc_write; // Launched cycle is a write.
	logic [`BPC_ADDR_W-1:0] cyc_addr; // Launched address.
	logic [`BPC_DATA_W-1:0] cyc_data; // Launched write data.
	logic cyc_done; // Bus cycle finished.
	logic [`BPC_DATA_W-1:0] cyc_rdata; // Bus cycle read data.

	// Buffer span check: the whole load must stay in one sector.
	wire [`BPC_SECT_LSB:0] span = {1'b0, cmd.addr[`BPC_SECT_LSB-1:0]}
		+ (`BPC_SECT_LSB+1)'(cmd.words_m1);
	wire crosses = span[`BPC_SECT_LSB];
	wire [`BPC_ADDR_W-1:0] sect_base = {sect_reg, {`BPC_SECT_LSB{1'b0}}};
	wire is_susp_op = (cmd.op == op_suspend);
	wire ready_bit = cyc_rdata[`BPC_SR_READY];
	wire err_bit = cyc_rdata[`BPC_SR_PROG_ERR];
	wire wr_launch = cyc_start && cyc_write && !wr_ready && state_reg != st_bypass_buffer_load;

	// Suspend is offered only after a busy poll.
	assign cmd_ready = (state_reg == st_bypass_idle) || (state_reg == st_bypass_program_suspended)
		|| (state_reg == st_bypass_programming && is_susp_op && busy_reg); // R6
	assign wr_ready = (state_reg == st_bypass_buffer_data)
		|| (state_reg == st_bypass_single_word_entry);

	// Step sequencing; each device access runs through st_wait.
	always_comb begin
		state_next = state_reg;
		ret_next = ret_reg;
		home_next = home_reg;
		cnt_next = cnt_reg;
		addr_next = addr_reg;
		sect_next = sect_reg;
		stat_next = stat_reg;
		busy_next = busy_reg;
		lat_next = lat_reg;
		done_next = 1'b0;
		fail_next = 1'b0;
		rdv_next = 1'b0;
		rdat_next = rdat_reg;
		cyc_start = 1'b0;
		cyc_write = 1'b1;
		cyc_addr = addr_reg;
		cyc_data = 16'h0000;
		case (state_reg)
			st_bypass_idle: begin
				if (cmd_valid) begin
					addr_next = cmd.addr;
					sect_next = cmd.addr[`BPC_ADDR_W-1:`BPC_SECT_LSB];
					cnt_next = {1'b0, cmd.words_m1};
					if (cmd.op == op_buf_prog) begin
						// A load that would leave its sector is refused before any write.
						if (crosses) begin
							fail_next = 1'b1; // R1
						end else begin
							state_next = st_buf_enter;
						end
					end else if (cmd.op == op_word_prog) begin
						state_next = st_word_cmd;
					end else if (cmd.op == op_read) begin
						state_next = st_array_read;
					end else if (cmd.op == op_status) begin
						state_next = st_stat_cmd;
					end else if (cmd.op == op_reset) begin
						state_next = st_sw_reset;
					end else begin
						fail_next = 1'b1;
					end
				end
			end
			st_buf_enter: begin
				// Open the write buffer at the target sector.
				cyc_start = 1'b1;
				cyc_addr = sect_base;
				cyc_data = `BPC_CMD_BUF_ENTER;
				ret_next = st_bypass_buffer_load;
				state_next = st_wait;
			end
			st_bypass_buffer_load: begin
				// Word count is words minus one and never above the limit.
				cyc_start = 1'b1;
				cyc_addr = sect_base;
				cyc_data = {9'h000, cnt_reg[6:0]}; // R1
				ret_next = st_bypass_buffer_data;
				state_next = st_wait;
			end
			st_bypass_buffer_data: begin
				// Each data word counts down by one; after the last it reads -1.
				if (wr_valid) begin
					cyc_start = 1'b1;
					cyc_data = wr_data;
					cnt_next = cnt_reg - 8'h01; // R2
					addr_next = addr_reg + `BPC_ADDR_W'(1);
					ret_next = (cnt_reg == 8'h00) ? st_buf_confirm : st_bypass_buffer_data;
					state_next = st_wait;
				end
			end
			st_buf_confirm: begin
				// Confirm goes to the loaded sector, which starts programming.
				cyc_start = 1'b1;
				cyc_addr = sect_base; // R3
				cyc_data = `BPC_CMD_CONFIRM;
				home_next = st_bypass_programming;
				busy_next = 1'b0;
				ret_next = st_bypass_programming;
				state_next = st_wait;
			end
			st_word_cmd: begin
				cyc_start = 1'b1;
				cyc_data = `BPC_CMD_WORD;
				ret_next = st_bypass_single_word_entry;
				state_next = st_wait;
			end
			st_bypass_single_word_entry: begin
				// The next data write itself starts programming.
				if (wr_valid) begin
					cyc_start = 1'b1;
					cyc_data = wr_data; // R12
					home_next = st_bypass_programming;
					busy_next = 1'b0;
					ret_next = st_bypass_programming;
					state_next = st_wait;
				end
			end
			st_bypass_programming: begin
				// While programming, only suspend or polls are sent.
				if (cmd_valid && is_susp_op && busy_reg) begin
					cyc_start = 1'b1;
					cyc_data = `BPC_CMD_SUSPEND; // R6 R11
					lat_next = 16'(SUSP_CYC - 1);
					ret_next = st_bypass_suspend_request;
					state_next = st_wait;
				end else begin
					state_next = st_stat_cmd; // R13
				end
			end
			st_stat_cmd: begin
				// Status read entry keeps the device state.
				cyc_start = 1'b1;
				cyc_addr = `BPC_ADDR_STATUS;
				cyc_data = `BPC_CMD_STATUS; // R10
				ret_next = st_stat_read;
				state_next = st_wait;
			end
			st_stat_read: begin
				cyc_start = 1'b1;
				cyc_write = 1'b0;
				stat_next = 1'b1;
				ret_next = st_check;
				state_next = st_wait;
			end
			st_array_read: begin
				cyc_start = 1'b1;
				cyc_write = 1'b0;
				stat_next = 1'b0;
				ret_next = st_check;
				state_next = st_wait;
			end
			st_check: begin
				rdat_next = cyc_rdata;
				if (home_reg == st_bypass_programming && stat_reg) begin
					if (!ready_bit) begin
						busy_next = 1'b1;
						state_next = st_bypass_programming;
					end else if (err_bit) begin
						// A hung operation only leaves through a software reset.
						state_next = st_sw_reset; // R5
					end else begin
						// The device returns to bypass idle by itself.
						done_next = 1'b1;
						home_next = st_bypass_idle; // R4
						state_next = st_bypass_idle;
					end
				end else begin
					rdv_next = 1'b1;
					state_next = home_reg;
				end
			end
			st_bypass_suspend_request: begin
				// Nothing is written while the device settles into suspend.
				if (lat_reg == 16'h0000) begin
					home_next = st_bypass_program_suspended; // R7
					state_next = st_bypass_program_suspended;
				end else begin
					lat_next = lat_reg - 16'h0001; // R13
				end
			end
			st_bypass_program_suspended: begin
				if (cmd_valid) begin
					addr_next = cmd.addr;
					if (cmd.op == op_resume) begin
						state_next = st_resume;
					end else if (cmd.op == op_read) begin
						state_next = st_array_read;
					end else if (cmd.op == op_status) begin
						state_next = st_stat_cmd;
					end else begin
						fail_next = 1'b1;
					end
				end
			end
			st_resume: begin
				// Either resume code restarts; enhanced is the default.
				cyc_start = 1'b1;
				cyc_data = LEGACY_RESUME ? `BPC_CMD_RESUME_OLD : `BPC_CMD_RESUME; // R8 R9
				home_next = st_bypass_programming;
				busy_next = 1'b0;
				ret_next = st_bypass_programming;
				state_next = st_wait;
			end
			st_sw_reset: begin
				// Fails when clearing a hung program, done otherwise.
				cyc_start = 1'b1;
				cyc_data = `BPC_CMD_RESET; // R5
				fail_next = (home_reg == st_bypass_programming);
				done_next = (home_reg != st_bypass_programming);
				home_next = st_bypass_idle;
				ret_next = st_bypass_idle;
				state_next = st_wait;
			end
			default: begin
				if (cyc_done) begin
					state_next = ret_reg;
				end
			end
		endcase
	end

	// State registers.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= st_bypass_idle;
			ret_reg <= st_bypass_idle;
			home_reg <= st_bypass_idle;
			cnt_reg <= 8'h00;
			addr_reg <= '0;
			sect_reg <= '0;
			stat_reg <= 1'b0;
			busy_reg <= 1'b0;
			lat_reg <= 16'h0000;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			rdv_reg <= 1'b0;
			rdat_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			ret_reg <= ret_next;
			home_reg <= home_next;
			cnt_reg <= cnt_next;
			addr_reg <= addr_next;
			sect_reg <= sect_next;
			stat_reg <= stat_next;
			busy_reg <= busy_next;
			lat_reg <= lat_next;
			done_reg <= done_next;
			fail_reg <= fail_next;
			rdv_reg <= rdv_next;
			rdat_reg <= rdat_next;
		end
	end

	assign done = done_reg;
	assign fail = fail_reg;
	assign rd_valid = rdv_reg;
	assign rd_data = rdat_reg;
	assign suspended = (home_reg == st_bypass_program_suspended);

	// One bus cycle engine drives all pins.
	bpc_bus_cycle u_cycle (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(cyc_start),
		.write(cyc_write),
		.addr(cyc_addr),
		.data(cyc_data),
		.dq_in(flash_dq_in),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.pins(flash_pins)
	);

	// Checks on what the controller sends.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	AST_WC_LIMIT: assert property (state_reg == st_bypass_buffer_load && cyc_start |-> // R1
		cyc_data <= 16'(`BPC_WC_MAX) && cyc_addr[`BPC_ADDR_W-1:`BPC_SECT_LSB] == sect_reg)
		else $error("word count write out of range or sector");
	AST_COUNTDOWN: assert property (state_reg == st_bypass_buffer_data && wr_valid |=> // R2
		cnt_reg == $past(cnt_reg) - 8'h01)
		else $error("countdown did not drop by one");
	AST_CONFIRM: assert property (wr_launch && cyc_data == `BPC_CMD_CONFIRM |-> // R3
		cnt_reg == 8'hff && cyc_addr[`BPC_ADDR_W-1:`BPC_SECT_LSB] == sect_reg)
		else $error("confirm sent early or to another sector");
	AST_AUTO_IDLE: assert property (state_reg == st_check && stat_reg && ready_bit // R4
		&& !err_bit && home_reg == st_bypass_programming |=> state_reg == st_bypass_idle && done)
		else $error("no return to idle after program end");
	AST_HANG_RESET: assert property (state_reg == st_check && stat_reg && ready_bit // R5
		&& err_bit && home_reg == st_bypass_programming |=> cyc_start && cyc_data == `BPC_CMD_RESET)
		else $error("hang not cleared by software reset");
	AST_SUSPEND_BUSY: assert property (wr_launch && cyc_data == `BPC_CMD_SUSPEND |-> // R6
		busy_reg && home_reg == st_bypass_programming)
		else $error("suspend sent while not programming");
	AST_SUSP_LAT: assert property (state_reg == st_bypass_suspend_request // R7
		&& lat_reg == 16'h0000 |=> state_reg == st_bypass_program_suspended)
		else $error("suspend latency end missed");
	AST_RESUME: assert property (wr_launch && (cyc_data == `BPC_CMD_RESUME // R8
		|| cyc_data == `BPC_CMD_RESUME_OLD) |-> $past(state_reg) == st_bypass_program_suspended)
		else $error("resume sent outside suspend");
	AST_STATUS_ADDR: assert property (wr_launch && cyc_data == `BPC_CMD_STATUS |-> // R10
		cyc_addr == `BPC_ADDR_STATUS)
		else $error("status entry at wrong address");
	AST_NO_OLD_SUSP: assert property (wr_launch |-> cyc_data != `BPC_CMD_SUSPEND_OLD) // R11
		else $error("legacy suspend code sent");
	AST_QUIET_SUSP: assert property (state_reg == st_bypass_suspend_request |-> !cyc_start) // R13
		else $error("write during suspend request");

	COV_BUF: cover property (state_reg == st_buf_confirm ##[1:300] done);
	COV_SUSP: cover property (state_reg == st_bypass_program_suspended ##1 state_reg == st_resume);
	COV_HANG: cover property (state_reg == st_sw_reset && home_reg == st_bypass_programming);

endmodule

// ==== bpc_flash_model.sv ====
// Purpose: Behavioural flash device for the bypass program controller.
// Assumes: The model samples the controller's clock.
// Notes: Timings are in clock cycles; a released data bus shows the inverse of its last value.
`timescale 1ns/100ps
module bpc_flash_model
	import bpc_pkg::*;
#(
	parameter int PROG_CYC = 300,
	parameter int SUSP_LAT = 3
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire bpc_pins_type pins,
	input wire logic hang_next,
	output logic [15:0] dq,
	output logic [2:0] state_reg,
	output logic [7:0] words_reg,
	output logic legacy_reg
);
	// Device states, also seen by the bench.
	localparam logic [2:0] IDLE = 3'h0, LOAD = 3'h1, DATA = 3'h2, ONE = 3'h3;
	localparam logic [2:0] PROG = 3'h4, SREQ = 3'h5, SUSP = 3'h6, PERR = 3'h7;
	logic we_reg, oe_reg, wce_reg, hang_reg, stat_reg;
	logic [21:0] wa_reg;
	logic [15:0] wd_reg, last_reg, stat;
	logic [15:0] busy_reg;
	logic [7:0] lat_reg;
	logic signed [16:0] wc_reg;
	logic [6:0] sect_reg;
	// A write is taken as the write strobe rises.
	wire wr_evt = !we_reg && pins.we_n && wce_reg;
	wire rd_en = !pins.ce_n && !pins.oe_n;
	wire same = wa_reg[21:15] == sect_reg;
	wire hung = hang_reg && busy_reg == 16'h0000;
	// Confirm at the loaded sector, or a single word, starts programming.
	wire go = wr_evt && ((state_reg == DATA && wc_reg < 0 && same && wd_reg == 16'h0029) ||
		state_reg == ONE);
	// Status: busy while programming; error set when hung or in error.
	assign stat = (hung || state_reg == PERR) ? 16'h0090 :
		(state_reg inside {PROG, SREQ}) ? 16'h0000 : 16'h0080;
	// Array data is a pattern of the address, so a wrong address shows up.
	assign dq = rd_en ? (stat_reg ? stat : pins.addr[15:0] ^ 16'h5a5a) : ~last_reg;

	// Command state machine; reads never touch the state.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{we_reg, oe_reg, wce_reg, hang_reg, stat_reg, legacy_reg} <= 6'b110000;
			{wa_reg, wd_reg, last_reg, sect_reg, busy_reg, lat_reg, wc_reg, words_reg} <= '0;
			state_reg <= IDLE;
		end else begin
			we_reg <= pins.we_n;
			oe_reg <= pins.oe_n;
			if (!pins.we_n) begin
				wa_reg <= pins.addr;
				wd_reg <= pins.dq_out;
				wce_reg <= !pins.ce_n;
			end
			if (rd_en) last_reg <= dq;
			// Status mode lasts for one read only.
			if (!oe_reg && pins.oe_n) stat_reg <= 1'b0;
			if (state_reg == PROG && busy_reg != 16'h0000) busy_reg <= busy_reg - 16'h0001;
			if (state_reg == PROG && busy_reg == 16'h0000 && !hang_reg) state_reg <= IDLE;
			if (state_reg == SREQ) lat_reg <= lat_reg + 8'h01;
			if (state_reg == SREQ && lat_reg == SUSP_LAT - 1) state_reg <= SUSP;
			if (wr_evt && wd_reg == 16'h0070 && wa_reg == 22'h000555) stat_reg <= 1'b1;
			else if (wr_evt && wd_reg == 16'h00b0) legacy_reg <= 1'b1;
			else if (wr_evt) begin
				case (state_reg)
					IDLE: begin
						if (wd_reg == 16'h0025) state_reg <= LOAD;
						if (wd_reg == 16'h00a0) state_reg <= ONE;
						sect_reg <= wa_reg[21:15];
						words_reg <= 8'h00;
					end
					LOAD: begin
						if (wd_reg > 16'd127 || !same) state_reg <= PERR;
						else state_reg <= DATA;
						wc_reg <= {1'b0, wd_reg};
					end
					DATA: begin
						if (wc_reg >= 0) begin
							wc_reg <= wc_reg - 17'sd1;
							words_reg <= words_reg + 8'h01;
						end else if (!same) state_reg <= PERR;
					end
					ONE: words_reg <= 8'h01;
					PROG: begin
						lat_reg <= 8'h00;
						if (wd_reg == 16'h0051 && busy_reg != 16'h0000) state_reg <= SREQ;
						else if (wd_reg == 16'h00f0 && hung) state_reg <= IDLE;
					end
					SUSP: if (wd_reg == 16'h0050 || wd_reg == 16'h0030) state_reg <= PROG;
					PERR: if (wd_reg == 16'h00f0) state_reg <= IDLE;
					// Other writes keep the state.
					default: ;
				endcase
				if (go) begin
					state_reg <= PROG;
					busy_reg <= PROG_CYC[15:0];
					hang_reg <= hang_next;
				end
			end
		end
	end
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the bypass program controller.
// Assumes: The flash model answers on the controller's pins.
// Notes: Plain cases run from a table; suspend, hang and reset follow by hand.
`timescale 1ns/100ps
module tb_top
	import bpc_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic wr_valid = 1'b0;
	logic hang_next = 1'b0;
	logic cmd_ready, wr_ready, done, fail, rd_valid, suspended, dev_legacy;
	bpc_cmd_type cmd = '{op: op_read, addr: '0, words_m1: '0};
	logic [15:0] wr_data = 16'h0000;
	logic [15:0] rd_data, flash_dq_in, rd_seen;
	bpc_pins_type flash_pins;
	logic [2:0] dev_state;
	logic [7:0] dev_words;
	logic [1:0] last_ev;
	int n_ev, words_need, words_taken, mismatches, check_count;
	// Row: command and expected answer (1 done, 2 fail, 3 read data).
	typedef struct {bpc_op_type op; logic [21:0] a; logic [6:0] m1; logic [1:0] ev;} bpc_tb_row_type;
	bpc_tb_row_type rows [10] = '{
		'{op_buf_prog, 22'h008000, 7'h00, 2'h1}, '{op_buf_prog, 22'h010010, 7'h03, 2'h1},
		'{op_buf_prog, 22'h018000, 7'h7f, 2'h1}, '{op_buf_prog, 22'h007ffe, 7'h03, 2'h2},
		'{op_word_prog, 22'h000123, 7'h00, 2'h1}, '{op_read, 22'h012345, 7'h00, 2'h3},
		'{op_status, 22'h000000, 7'h00, 2'h3}, '{op_reset, 22'h000000, 7'h00, 2'h1},
		'{op_suspend, 22'h000000, 7'h00, 2'h2}, '{op_resume, 22'h000000, 7'h00, 2'h2}};

	always #5 clk_sys = ~clk_sys;

	bpc_host #(.SUSP_CYC(5), .LEGACY_RESUME(1'b0)) dut (.clk_sys(clk_sys), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_data(wr_data), .done(done), .fail(fail), .rd_valid(rd_valid),
		.rd_data(rd_data), .suspended(suspended), .flash_dq_in(flash_dq_in),
		.flash_pins(flash_pins));
	bpc_flash_model #(.PROG_CYC(300), .SUSP_LAT(3)) flash (.clk_sys(clk_sys), .rst(rst),
		.pins(flash_pins), .hang_next(hang_next), .dq(flash_dq_in), .state_reg(dev_state),
		.words_reg(dev_words), .legacy_reg(dev_legacy));

	// Handshakes and pulses are sampled on the edge.
	always @(posedge clk_sys) begin
		if (cmd_valid && cmd_ready) cmd_valid <= 1'b0;
		if (wr_valid && wr_ready) begin
			words_taken <= words_taken + 1;
			wr_data <= wr_data + 16'h0001;
			if (words_taken + 1 >= words_need) wr_valid <= 1'b0;
		end
		if (done || fail || rd_valid) n_ev <= n_ev + 1;
		if (done) last_ev <= 2'h1;
		if (fail) last_ev <= 2'h2;
		if (rd_valid) last_ev <= 2'h3;
		if (rd_valid) rd_seen <= rd_data;
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// Presents a command and any data words it needs.
	task automatic issue(input bpc_op_type op, input logic [21:0] a, input logic [6:0] m1);
		@(posedge clk_sys);
		cmd <= '{op: op, addr: a, words_m1: m1};
		cmd_valid <= 1'b1;
		words_taken <= 0;
		words_need <= (op == op_word_prog) ? 1 : int'(m1) + 1;
		wr_data <= 16'h1000;
		wr_valid <= op inside {op_buf_prog, op_word_prog};
	endtask

	// Bounded wait for the answer; the settle lets a last write land in the device.
	task automatic run_op(input bpc_op_type op, input logic [21:0] a, input logic [6:0] m1);
		int k, ev0;
		issue(op, a, m1);
		ev0 = n_ev;
		k = 0;
		while (n_ev == ev0 && k < 5000) begin
			@(posedge clk_sys);
			k++;
		end
		check("answer in time", 16'(k < 5000), 16'h0001);
		repeat (6) @(posedge clk_sys);
		if (wr_valid) wr_valid <= 1'b0;
	endtask

	initial begin
		int k;
		repeat (15) @(posedge clk_sys);
		@(negedge clk_sys);
		check("reset cmd_ready", cmd_ready, 16'h0001);
		check("reset chip select", flash_pins.ce_n, 16'h0001);
		@(posedge clk_sys);
		rst <= 1'b0;
		foreach (rows[i]) begin
			run_op(rows[i].op, rows[i].a, rows[i].m1);
			check("answer kind", last_ev, rows[i].ev);
			check("device state", dev_state, 16'h0000);
			if (rows[i].ev == 2'h3) check("read data", rd_seen, (rows[i].op == op_status) ?
				16'h0080 : rows[i].a[15:0] ^ 16'h5a5a);
			if (rows[i].ev == 2'h1 && rows[i].op inside {op_buf_prog, op_word_prog})
				check("words taken", dev_words, 16'(rows[i].m1) + 16'h0001);
		end
		// Hung program, cleared by reset.
		hang_next <= 1'b1;
		run_op(op_word_prog, 22'h000200, 7'h00);
		hang_next <= 1'b0;
		check("hang answer", last_ev, 16'h0002);
		check("hang state", dev_state, 16'h0000);
		// Suspend, look around, resume.
		issue(op_buf_prog, 22'h020000, 7'h01);
		k = 0;
		while (dev_state !== 3'h4 && k < 2000) begin
			@(posedge clk_sys);
			k++;
		end
		issue(op_suspend, 22'h000000, 7'h00);
		k = 0;
		while (suspended !== 1'b1 && k < 2000) begin
			@(posedge clk_sys);
			k++;
		end
		check("suspended flag", suspended, 16'h0001);
		check("suspend state", dev_state, 16'h0006);
		run_op(op_status, 22'h000000, 7'h00);
		check("suspend status", rd_seen, 16'h0080);
		run_op(op_read, 22'h020004, 7'h00);
		check("suspend read", rd_seen, 16'h5a5e);
		check("suspend kept", dev_state, 16'h0006);
		run_op(op_reset, 22'h000000, 7'h00);
		check("refused in suspend", last_ev, 16'h0002);
		run_op(op_resume, 22'h000000, 7'h00);
		check("resume answer", last_ev, 16'h0001);
		check("resume words", dev_words, 16'h0002);
		check("resume cleared", suspended, 16'h0000);
		check("old suspend unused", dev_legacy, 16'h0000);
		// Mid-program reset idles the pins.
		issue(op_word_prog, 22'h000300, 7'h00);
		repeat (40) @(posedge clk_sys);
		rst <= 1'b1;
		@(negedge clk_sys);
		check("mid reset select", flash_pins.ce_n, 16'h0001);
		check("mid reset ready", cmd_ready, 16'h0001);
		@(posedge clk_sys);
		rst <= 1'b0;
		run_op(op_status, 22'h000000, 7'h00);
		check("status after reset", rd_seen, 16'h0080);
		results();
	end

	// Run needs under 20000 cycles; limit is three times that.
	initial begin
		#600000;
		mismatches++;
		results();
	end
endmodule
